// ===== include/dlfa_pkg.sv
/*
  Shared constants and types for the decimated lane frame assembly block.
  Assumes a single core clock domain and the serial control port framing used by the main module.
*/
package dlfa_pkg;

  // ****************************************************************
  // Sample path and buffering.
  // ****************************************************************
  localparam int SAMPLE_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam logic [1:0] PHASE_LAST = 2'h3;

  // ****************************************************************
  // Lane format codes and expected setup values.
  // ****************************************************************
  localparam logic [2:0] MODE_FOUR_LANE = 3'h1;
  localparam logic [2:0] MODE_TWO_LANE = 3'h2;
  localparam logic [7:0] PLL_FOUR_LANE = 8'h00;
  localparam logic [7:0] PLL_TWO_LANE = 8'h10;
  localparam logic [7:0] ORDER_OK = 8'h0A;
  localparam logic [7:0] SETUP_A_OK = 8'h80;
  localparam logic [7:0] SETUP_B_OK = 8'h08;
  localparam logic [3:0] VALID_FOUR_LANE = 4'h3;
  localparam logic [3:0] VALID_TWO_LANE = 4'h2;

  // ****************************************************************
  // Bank, page and register locations.
  // ****************************************************************
  localparam logic [11:0] ADDR_LINK_PAGE_LO = 12'h003;
  localparam logic [11:0] ADDR_LINK_PAGE_HI = 12'h004;
  localparam logic [11:0] ADDR_BCAST_OFF = 12'h005;
  localparam logic [11:0] ADDR_ANALOG_PAGE = 12'h011;
  localparam logic [11:0] ADDR_SETUP_A = 12'h052;
  localparam logic [11:0] ADDR_SETUP_B = 12'h072;
  localparam logic [11:0] ADDR_LANE_FMT = 12'h001;
  localparam logic [11:0] ADDR_ORDER = 12'h002;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [11:0] ADDR_PLL = 12'h016;
  localparam logic [15:0] PAGE_MAIN_DIG = 16'h6800;
  localparam logic [15:0] PAGE_LINK_DIG = 16'h6900;
  localparam logic [15:0] PAGE_LINK_ANA = 16'h6A00;
  localparam logic [7:0] APAGE_MASTER = 8'h80;
  localparam logic [7:0] APAGE_CONV = 8'h0F;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ****************************************************************
  // Serial control word layout.
  // ****************************************************************
  localparam int SPI_BITS = 24;
  localparam int RW_BIT = 23;
  localparam int M_BIT = 22;
  localparam int P_BIT = 21;
  localparam int CH_BIT = 20;
  localparam int ADDR_MSB = 19;
  localparam int ADDR_LSB = 8;
  localparam logic [4:0] CNT_ADDR_DONE = 5'h0F;
  localparam logic [4:0] CNT_WORD_DONE = 5'h17;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum logic [3:0] {
    SEL_NONE, SEL_APAGE, SEL_JLO, SEL_JHI, SEL_BCAST, SEL_SETUP_A, SEL_SETUP_B,
    SEL_FMT, SEL_ORDER, SEL_STATUS, SEL_PLL
  } dlfa_sel_type;

  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_SEND = 2'b01
  } dlfa_frame_state_type;

  typedef struct packed {
    logic [SAMPLE_W-1:0] chan_a;
    logic [SAMPLE_W-1:0] chan_b;
  } dlfa_sample_type;

  typedef struct packed {
    logic [7:0] chan_a_lane0;
    logic [7:0] chan_a_lane1;
    logic [7:0] chan_a_lane2;
    logic [7:0] chan_a_lane3;
    logic [7:0] chan_b_lane0;
    logic [7:0] chan_b_lane1;
    logic [7:0] chan_b_lane2;
    logic [7:0] chan_b_lane3;
    logic [3:0] valid;
  } dlfa_lane_bus_type;

endpackage

// ===== rtl/dlfa_fifo.sv
/*
  Flip-flop FIFO with valid and ready on both sides.
  Assumes one clock and a synchronous active-high reset; DEPTH is a power of two.
*/
`timescale 1ns/10ps
`default_nettype none
module dlfa_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [AW:0] count_reg, count_next;
  logic push, pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/dlfa_top.sv
/*
  Transport frame assembly for two decimated channels, with the serial control banks.
  Assumes a 25 MHz core clock, samples supplied on the core clock, and control pins from outside.
*/
`timescale 1ns/10ps
`default_nettype none
module dlfa_top (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Sample input.
  input wire logic sample_valid,
  output logic sample_ready,
  input wire dlfa_pkg::dlfa_sample_type sample_data,
  output logic sample_tick,
  // Lane output.
  output dlfa_pkg::dlfa_lane_bus_type lanes,
  // Serial control pins.
  input wire logic ctrl_sclk,
  input wire logic ctrl_sen_n,
  input wire logic ctrl_sdin,
  output logic ctrl_sdout,
  // Status.
  output logic link_config_ok,
  output logic analog_page_master,
  output logic analog_page_conv
);
  // ****************************************************************
  // Control pin synchronisers and serial shifter.
  // ****************************************************************
  logic [2:0] pin_meta_reg, pin_sync_reg;
  logic sclk_prev_reg;
  logic [23:0] shift_reg, shift_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [7:0] rd_shift_reg, rd_shift_next;
  logic sdout_reg, sdout_next;
  logic rise, fall, commit;
  logic [23:0] word;
  dlfa_pkg::dlfa_sel_type wr_sel, rd_sel;

  assign rise = pin_sync_reg[0] && !sclk_prev_reg && !pin_sync_reg[1];
  assign fall = !pin_sync_reg[0] && sclk_prev_reg && !pin_sync_reg[1];
  assign word = {shift_reg[22:0], pin_sync_reg[2]};
  assign commit = rise && (cnt_reg == dlfa_pkg::CNT_WORD_DONE) && !word[dlfa_pkg::RW_BIT];
  assign ctrl_sdout = sdout_reg;

  // ****************************************************************
  // Control registers.
  // ****************************************************************
  logic [7:0] apage_reg, jlo_reg, jhi_reg, bcast_reg, setup_a_reg, setup_b_reg;
  logic [7:0] fmt_reg, order_a_reg, order_b_reg, pll_reg;
  logic [7:0] apage_next, jlo_next, jhi_next, bcast_next, setup_a_next, setup_b_next;
  logic [7:0] fmt_next, order_a_next, order_b_next, pll_next;
  logic [7:0] status_val, rd_val;
  logic fmt_four, fmt_two, fifo_ready;

  function automatic dlfa_pkg::dlfa_sel_type decode(input logic m, input logic p,
                                                    input logic [11:0] addr,
                                                    input logic [15:0] page);
    decode = dlfa_pkg::SEL_NONE;
    if (!m) begin
      if (addr == dlfa_pkg::ADDR_ANALOG_PAGE) decode = dlfa_pkg::SEL_APAGE;
    end else if (!p) begin
      if (addr == dlfa_pkg::ADDR_LINK_PAGE_LO) decode = dlfa_pkg::SEL_JLO;
      if (addr == dlfa_pkg::ADDR_LINK_PAGE_HI) decode = dlfa_pkg::SEL_JHI;
      if (addr == dlfa_pkg::ADDR_BCAST_OFF) decode = dlfa_pkg::SEL_BCAST;
    end else if (page == dlfa_pkg::PAGE_MAIN_DIG) begin
      if (addr == dlfa_pkg::ADDR_SETUP_A) decode = dlfa_pkg::SEL_SETUP_A;
      if (addr == dlfa_pkg::ADDR_SETUP_B) decode = dlfa_pkg::SEL_SETUP_B;
    end else if (page == dlfa_pkg::PAGE_LINK_DIG) begin
      if (addr == dlfa_pkg::ADDR_LANE_FMT) decode = dlfa_pkg::SEL_FMT;
      if (addr == dlfa_pkg::ADDR_ORDER) decode = dlfa_pkg::SEL_ORDER;
      if (addr == dlfa_pkg::ADDR_STATUS) decode = dlfa_pkg::SEL_STATUS;
    end else if (page == dlfa_pkg::PAGE_LINK_ANA) begin
      if (addr == dlfa_pkg::ADDR_PLL) decode = dlfa_pkg::SEL_PLL;
    end
  endfunction

  assign wr_sel = decode(word[dlfa_pkg::M_BIT], word[dlfa_pkg::P_BIT],
                         word[dlfa_pkg::ADDR_MSB:dlfa_pkg::ADDR_LSB], {jhi_reg, jlo_reg});
  assign rd_sel = decode(word[dlfa_pkg::M_BIT-8], word[dlfa_pkg::P_BIT-8],
                         word[dlfa_pkg::ADDR_MSB-8:dlfa_pkg::ADDR_LSB-8], {jhi_reg, jlo_reg});
  assign fmt_four = (fmt_reg[2:0] == dlfa_pkg::MODE_FOUR_LANE);
  assign fmt_two = (fmt_reg[2:0] == dlfa_pkg::MODE_TWO_LANE);
  assign analog_page_master = (apage_reg == dlfa_pkg::APAGE_MASTER);
  assign analog_page_conv = (apage_reg == dlfa_pkg::APAGE_CONV);
  // The link parameters sent at alignment are only correct with this setup in place.
  assign link_config_ok = (order_a_reg == dlfa_pkg::ORDER_OK) &&
    (order_b_reg == dlfa_pkg::ORDER_OK) && (setup_a_reg == dlfa_pkg::SETUP_A_OK) &&
    (setup_b_reg == dlfa_pkg::SETUP_B_OK) &&
    ((fmt_four && pll_reg == dlfa_pkg::PLL_FOUR_LANE) ||
     (fmt_two && pll_reg == dlfa_pkg::PLL_TWO_LANE));
  assign status_val = {5'h00, !fifo_ready, link_config_ok, lanes.valid != 4'h0};

  always_comb begin
    unique case (rd_sel)
      dlfa_pkg::SEL_APAGE: rd_val = apage_reg;
      dlfa_pkg::SEL_JLO: rd_val = jlo_reg;
      dlfa_pkg::SEL_JHI: rd_val = jhi_reg;
      dlfa_pkg::SEL_BCAST: rd_val = bcast_reg;
      dlfa_pkg::SEL_SETUP_A: rd_val = setup_a_reg;
      dlfa_pkg::SEL_SETUP_B: rd_val = setup_b_reg;
      dlfa_pkg::SEL_FMT: rd_val = fmt_reg;
      dlfa_pkg::SEL_ORDER: rd_val = word[dlfa_pkg::CH_BIT-8] ? order_b_reg : order_a_reg;
      dlfa_pkg::SEL_STATUS: rd_val = status_val;
      dlfa_pkg::SEL_PLL: rd_val = pll_reg;
      default: rd_val = 8'h00;
    endcase
  end

  always_comb begin
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    rd_shift_next = rd_shift_reg;
    sdout_next = sdout_reg;
    if (pin_sync_reg[1]) begin
      cnt_next = 5'h00;
    end else if (rise) begin
      shift_next = word;
      cnt_next = cnt_reg + 1'b1;
      if (cnt_reg == dlfa_pkg::CNT_ADDR_DONE) begin
        rd_shift_next = rd_val;
      end
    end else if (fall) begin
      sdout_next = rd_shift_reg[7];
      rd_shift_next = {rd_shift_reg[6:0], 1'b0};
    end
  end

  always_comb begin
    apage_next = apage_reg;
    jlo_next = jlo_reg;
    jhi_next = jhi_reg;
    bcast_next = bcast_reg;
    setup_a_next = setup_a_reg;
    setup_b_next = setup_b_reg;
    fmt_next = fmt_reg;
    order_a_next = order_a_reg;
    order_b_next = order_b_reg;
    pll_next = pll_reg;
    if (commit) begin
      unique case (wr_sel)
        dlfa_pkg::SEL_APAGE: apage_next = word[7:0];
        dlfa_pkg::SEL_JLO: jlo_next = word[7:0];
        dlfa_pkg::SEL_JHI: jhi_next = word[7:0];
        dlfa_pkg::SEL_BCAST: bcast_next = word[7:0];
        dlfa_pkg::SEL_SETUP_A: setup_a_next = word[7:0];
        dlfa_pkg::SEL_SETUP_B: setup_b_next = word[7:0];
        dlfa_pkg::SEL_FMT: fmt_next = word[7:0];
        dlfa_pkg::SEL_ORDER: begin
          if (!bcast_reg[0] || !word[dlfa_pkg::CH_BIT]) order_a_next = word[7:0];
          if (!bcast_reg[0] || word[dlfa_pkg::CH_BIT]) order_b_next = word[7:0];
        end
        dlfa_pkg::SEL_PLL: pll_next = word[7:0];
        default: apage_next = apage_reg;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_meta_reg <= 3'h3;
      pin_sync_reg <= 3'h3;
      sclk_prev_reg <= 1'b1;
      shift_reg <= '0;
      cnt_reg <= '0;
      rd_shift_reg <= '0;
      sdout_reg <= 1'b0;
      {apage_reg, jlo_reg, jhi_reg, bcast_reg, setup_a_reg} <= {5{dlfa_pkg::REG_RESET}};
      {setup_b_reg, fmt_reg, order_a_reg, order_b_reg, pll_reg} <= {5{dlfa_pkg::REG_RESET}};
    end else begin
      pin_meta_reg <= {ctrl_sdin, ctrl_sen_n, ctrl_sclk};
      pin_sync_reg <= pin_meta_reg;
      sclk_prev_reg <= pin_sync_reg[0];
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      rd_shift_reg <= rd_shift_next;
      sdout_reg <= sdout_next;
      {apage_reg, jlo_reg, jhi_reg, bcast_reg, setup_a_reg} <=
        {apage_next, jlo_next, jhi_next, bcast_next, setup_a_next};
      {setup_b_reg, fmt_reg, order_a_reg, order_b_reg, pll_reg} <=
        {setup_b_next, fmt_next, order_a_next, order_b_next, pll_next};
    end
  end

  // ****************************************************************
  // Sample strobe, buffer and frame assembly.
  // ****************************************************************
  logic tick_reg, tick_next;
  logic fifo_valid, fifo_pop;
  dlfa_pkg::dlfa_sample_type fifo_data;
  dlfa_pkg::dlfa_sample_type stage0_reg, stage0_next, stage1_reg, stage1_next;
  dlfa_pkg::dlfa_sample_type frm0_reg, frm0_next, frm1_reg, frm1_next;
  logic [1:0] stage_cnt_reg, stage_cnt_next;
  logic [1:0] phase_reg, phase_next;
  dlfa_pkg::dlfa_frame_state_type state_reg, state_next;
  dlfa_pkg::dlfa_lane_bus_type lanes_next;
  logic take_frame;

  assign sample_tick = tick_reg;
  assign sample_ready = fifo_ready && tick_reg;
  assign fifo_pop = (stage_cnt_reg != 2'h2) && fifo_valid;
  assign take_frame = (stage_cnt_reg == 2'h2) && (fmt_four || fmt_two) &&
    ((state_reg == dlfa_pkg::FR_IDLE) || (phase_reg == dlfa_pkg::PHASE_LAST));

  dlfa_fifo #(
    .WIDTH(2 * dlfa_pkg::SAMPLE_W),
    .DEPTH(dlfa_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .in_valid(sample_valid && tick_reg),
    .in_ready(fifo_ready),
    .in_data(sample_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  always_comb begin
    tick_next = !tick_reg;
    stage0_next = stage0_reg;
    stage1_next = stage1_reg;
    stage_cnt_next = take_frame ? 2'h0 : stage_cnt_reg;
    if (fifo_pop) begin
      if (stage_cnt_reg == 2'h0) stage0_next = fifo_data;
      else stage1_next = fifo_data;
      stage_cnt_next = stage_cnt_reg + 1'b1;
    end
    frm0_next = take_frame ? stage0_reg : frm0_reg;
    frm1_next = take_frame ? stage1_reg : frm1_reg;
    state_next = state_reg;
    phase_next = phase_reg + 1'b1;
    if (take_frame) begin
      state_next = dlfa_pkg::FR_SEND;
      phase_next = 2'h0;
    end else if (phase_reg == dlfa_pkg::PHASE_LAST || !(fmt_four || fmt_two)) begin
      state_next = dlfa_pkg::FR_IDLE;
    end
    lanes_next = '0;
    if (state_reg == dlfa_pkg::FR_SEND && fmt_four && !phase_reg[0]) begin
      // One octet every second cycle per lane: two octets per lane per frame.
      lanes_next.valid = dlfa_pkg::VALID_FOUR_LANE;
      lanes_next.chan_a_lane0 = phase_reg[1] ? frm1_reg.chan_a[7:0] : frm1_reg.chan_a[15:8];
      lanes_next.chan_a_lane1 = phase_reg[1] ? frm0_reg.chan_a[7:0] : frm0_reg.chan_a[15:8];
      lanes_next.chan_b_lane0 = phase_reg[1] ? frm1_reg.chan_b[7:0] : frm1_reg.chan_b[15:8];
      lanes_next.chan_b_lane1 = phase_reg[1] ? frm0_reg.chan_b[7:0] : frm0_reg.chan_b[15:8];
    end else if (state_reg == dlfa_pkg::FR_SEND && fmt_two) begin
      // Four octets per frame on lane 1, one per cycle.
      lanes_next.valid = dlfa_pkg::VALID_TWO_LANE;
      unique case (phase_reg)
        2'h0: {lanes_next.chan_a_lane1, lanes_next.chan_b_lane1} =
          {frm0_reg.chan_a[15:8], frm0_reg.chan_b[15:8]};
        2'h1: {lanes_next.chan_a_lane1, lanes_next.chan_b_lane1} =
          {frm0_reg.chan_a[7:0], frm0_reg.chan_b[7:0]};
        2'h2: {lanes_next.chan_a_lane1, lanes_next.chan_b_lane1} =
          {frm1_reg.chan_a[15:8], frm1_reg.chan_b[15:8]};
        2'h3: {lanes_next.chan_a_lane1, lanes_next.chan_b_lane1} =
          {frm1_reg.chan_a[7:0], frm1_reg.chan_b[7:0]};
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tick_reg <= 1'b0;
      stage0_reg <= '0;
      stage1_reg <= '0;
      stage_cnt_reg <= '0;
      frm0_reg <= '0;
      frm1_reg <= '0;
      phase_reg <= '0;
      state_reg <= dlfa_pkg::FR_IDLE;
      lanes <= '0;
    end else begin
      tick_reg <= tick_next;
      stage0_reg <= stage0_next;
      stage1_reg <= stage1_next;
      stage_cnt_reg <= stage_cnt_next;
      frm0_reg <= frm0_next;
      frm1_reg <= frm1_next;
      phase_reg <= phase_next;
      state_reg <= state_next;
      lanes <= lanes_next;
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  property p_tick_half;
    @(posedge core_clk) disable iff (srst) tick_reg |=> !tick_reg ##1 tick_reg;
  endproperty
  a_tick_half: assert property (p_tick_half) else $error("Sample strobe not half rate.");

  property p_four_lane_map;
    @(posedge core_clk) disable iff (srst)
      (state_reg == dlfa_pkg::FR_SEND && fmt_four && phase_reg == 2'h0) |=>
      (lanes.chan_a_lane0 == $past(frm1_reg.chan_a[15:8]) &&
       lanes.chan_b_lane1 == $past(frm0_reg.chan_b[15:8]) &&
       lanes.valid == dlfa_pkg::VALID_FOUR_LANE);
  endproperty
  a_four_lane_map: assert property (p_four_lane_map) else $error("Four-lane map wrong.");

  property p_two_lane_map;
    @(posedge core_clk) disable iff (srst)
      (state_reg == dlfa_pkg::FR_SEND && fmt_two && phase_reg == 2'h1) |=>
      (lanes.chan_a_lane1 == $past(frm0_reg.chan_a[7:0]) &&
       lanes.valid == dlfa_pkg::VALID_TWO_LANE);
  endproperty
  a_two_lane_map: assert property (p_two_lane_map) else $error("Two-lane map wrong.");

  property p_four_lane_rate;
    @(posedge core_clk) disable iff (srst) (lanes.valid[0] && fmt_four) |=> !lanes.valid[0];
  endproperty
  a_four_lane_rate: assert property (p_four_lane_rate) else $error("Lane rate too high.");

  property p_bank_split;
    @(posedge core_clk) disable iff (srst) (commit && !word[dlfa_pkg::M_BIT]) |=>
      ($stable(setup_a_reg) && $stable(fmt_reg) && $stable(jhi_reg));
  endproperty
  a_bank_split: assert property (p_bank_split) else $error("Analog write hit link bank.");

  property p_analog_page;
    @(posedge core_clk) disable iff (srst)
      (commit && wr_sel == dlfa_pkg::SEL_APAGE && word[7:0] == dlfa_pkg::APAGE_CONV) |=>
      (analog_page_conv && !analog_page_master);
  endproperty
  a_analog_page: assert property (p_analog_page) else $error("Converter page not chosen.");

  property p_link_page;
    @(posedge core_clk) disable iff (srst)
      (commit && wr_sel == dlfa_pkg::SEL_JHI && word[7:0] == dlfa_pkg::PAGE_LINK_DIG[15:8] &&
       jlo_reg == dlfa_pkg::PAGE_LINK_DIG[7:0]) |=>
      ({jhi_reg, jlo_reg} == dlfa_pkg::PAGE_LINK_DIG);
  endproperty
  a_link_page: assert property (p_link_page) else $error("Link page not selected.");
endmodule
`default_nettype wire

// ===== test/dlfa_lane_sink.sv
/*
  Link receiver stand-in that collects lane octets per channel.
  Assumes the lane bus of the frame assembly block on the core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module dlfa_lane_sink (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Lanes.
  input wire dlfa_pkg::dlfa_lane_bus_type lanes
);
  logic [7:0] qa[$];
  logic [7:0] qb[$];
  logic [3:0] qv[$];
  int n_stray = 0;
  // Lane 1 octets go in before lane 0 octets of the same cycle.
  always @(posedge core_clk) begin
    if (!srst && lanes.valid != 4'h0) begin
      qv.push_back(lanes.valid);
      if (lanes.valid[1]) qa.push_back(lanes.chan_a_lane1);
      if (lanes.valid[1]) qb.push_back(lanes.chan_b_lane1);
      if (lanes.valid[0]) qa.push_back(lanes.chan_a_lane0);
      if (lanes.valid[0]) qb.push_back(lanes.chan_b_lane0);
    end
    if ({lanes.chan_a_lane2, lanes.chan_a_lane3, lanes.chan_b_lane2, lanes.chan_b_lane3} != 0)
      n_stray++;
    if (!lanes.valid[0] && {lanes.chan_a_lane0, lanes.chan_b_lane0} != 16'h0000) n_stray++;
  end
endmodule
`default_nettype wire

// ===== test/test_dlfa_top.sv
/*
  Self-checking bench for the frame assembly block.
  Assumes the lane sink model and the design package are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module test_dlfa_top;
  logic core_clk, srst, sample_valid, sample_ready, sample_tick;
  logic ctrl_sclk, ctrl_sen_n, ctrl_sdin, ctrl_sdout, cfg_ok, pg_m, pg_c;
  dlfa_pkg::dlfa_sample_type sample_data;
  dlfa_pkg::dlfa_lane_bus_type lanes;
  int failures = 0;
  int n_compared = 0;
  logic [7:0] q;

  dlfa_top dlfa_top_i (.core_clk(core_clk), .srst(srst), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_data(sample_data), .sample_tick(sample_tick),
    .lanes(lanes), .ctrl_sclk(ctrl_sclk), .ctrl_sen_n(ctrl_sen_n), .ctrl_sdin(ctrl_sdin),
    .ctrl_sdout(ctrl_sdout), .link_config_ok(cfg_ok), .analog_page_master(pg_m),
    .analog_page_conv(pg_c));
  dlfa_lane_sink dlfa_lane_sink_i (.core_clk(core_clk), .srst(srst), .lanes(lanes));

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic finish_test();
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Sends one 24-bit control word MSB first; the last octet shifted out is returned.
  task automatic spi(input logic [2:0] rmp, input logic [11:0] a, input logic [7:0] d);
    logic [23:0] w;
    w = {rmp, 1'b0, a, d};
    ctrl_sen_n <= 1'b0;
    wait_n(8);
    for (int i = 23; i >= 0; i--) begin
      ctrl_sdin <= w[i];
      ctrl_sclk <= 1'b0;
      wait_n(8);
      if (i < 8) q = {q[6:0], ctrl_sdout};
      ctrl_sclk <= 1'b1;
      wait_n(8);
    end
    ctrl_sclk <= 1'b0;
    wait_n(8);
    ctrl_sen_n <= 1'b1;
    wait_n(8);
  endtask
  task automatic page(input logic [7:0] hi);
    spi(3'b010, 12'h003, 8'h00);
    spi(3'b010, 12'h004, hi);
  endtask
  task automatic push(input logic [31:0] d, output logic ok);
    ok = 1'b0;
    sample_data <= d;
    sample_valid <= 1'b1;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(negedge core_clk);
      ok = (sample_ready === 1'b1);
    end
    @(posedge core_clk);
  endtask
  task automatic drain(input int n);
    for (int i = 0; i < 400 && dlfa_lane_sink_i.qa.size() < n; i++) wait_n(1);
    if (dlfa_lane_sink_i.qa.size() < n) begin
      failures++;
      finish_test();
    end
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset();
    logic prev;
    spi(3'b110, 12'h004, 8'h00);
    chk(q, 8'h00);
    chk({cfg_ok, pg_m, pg_c}, 3'b000);
    @(negedge core_clk);
    prev = sample_tick;
    repeat (6) begin
      @(negedge core_clk);
      chk(sample_tick, !prev);
      prev = sample_tick;
    end
    @(posedge core_clk);
  endtask
  task automatic t_pages();
    spi(3'b000, 12'h011, 8'h80);
    chk({pg_m, pg_c}, 2'b10);
    spi(3'b000, 12'h011, 8'h0F);
    chk({pg_m, pg_c}, 2'b01);
    page(8'h68);
    spi(3'b110, 12'h004, 8'h00);
    chk(q, 8'h68);
    spi(3'b011, 12'h052, 8'h80);
    spi(3'b011, 12'h072, 8'h08);
    spi(3'b111, 12'h052, 8'h00);
    chk(q, 8'h80);
    spi(3'b111, 12'h053, 8'h00);
    chk(q, 8'h00);
  endtask
  // Programs one lane format, then checks one frame of two sample pairs.
  task automatic t_frame(input logic [7:0] pll, input logic [7:0] fmt, input logic [31:0] ea,
      input logic [31:0] eb, input logic [3:0] v);
    logic ok;
    page(8'h69);
    spi(3'b011, 12'h001, fmt);
    spi(3'b011, 12'h002, 8'h0A);
    page(8'h6A);
    spi(3'b011, 12'h016, pll);
    chk(cfg_ok, 1'b1);
    push(32'hA0A1_B0B1, ok);
    chk(ok, 1'b1);
    push(32'hA2A3_B2B3, ok);
    chk(ok, 1'b1);
    sample_valid <= 1'b0;
    drain(4);
    chk({dlfa_lane_sink_i.qa[0], dlfa_lane_sink_i.qa[1], dlfa_lane_sink_i.qa[2],
      dlfa_lane_sink_i.qa[3]}, ea);
    chk({dlfa_lane_sink_i.qb[0], dlfa_lane_sink_i.qb[1], dlfa_lane_sink_i.qb[2],
      dlfa_lane_sink_i.qb[3]}, eb);
    chk(dlfa_lane_sink_i.qv[0], v);
    chk(dlfa_lane_sink_i.qv.size(), fmt == 8'h01 ? 2 : 4);
    chk(dlfa_lane_sink_i.n_stray, 0);
    dlfa_lane_sink_i.qa.delete();
    dlfa_lane_sink_i.qb.delete();
    dlfa_lane_sink_i.qv.delete();
  endtask
  // With no valid format the buffer fills and refuses, then drains in order.
  task automatic t_fill();
    logic ok;
    int n;
    n = 0;
    page(8'h69);
    spi(3'b011, 12'h001, 8'h00);
    for (int i = 0; i < 16; i++) begin
      push({8'hC0 + 8'(i), 8'h11, 8'hD0 + 8'(i), 8'h22}, ok);
      if (ok) n++;
    end
    sample_valid <= 1'b0;
    chk(n < 16, 1'b1);
    spi(3'b111, 12'h010, 8'h00);
    chk(q[2], 1'b1);
    spi(3'b011, 12'h001, 8'h02);
    drain((n / 2) * 4);
    chk({dlfa_lane_sink_i.qa[0], dlfa_lane_sink_i.qa[2]}, 16'hC0C1);
    chk(dlfa_lane_sink_i.n_stray, 0);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    srst = 1'b1;
    sample_valid = 1'b0;
    sample_data = '0;
    ctrl_sclk = 1'b0;
    ctrl_sen_n = 1'b1;
    ctrl_sdin = 1'b0;
    q = 8'h00;
    wait_n(20);
    srst <= 1'b0;
    wait_n(4);
    t_reset();
    t_pages();
    t_frame(8'h00, 8'h01, 32'hA0A2_A1A3, 32'hB0B2_B1B3, 4'h3);
    t_frame(8'h10, 8'h02, 32'hA0A1_A2A3, 32'hB0B1_B2B3, 4'h2);
    t_fill();
    finish_test();
  end
endmodule
`default_nettype wire
